// ===== verilog/pam_consts.vh
`ifndef PAM_CONSTS_VH
`define PAM_CONSTS_VH

// axi4-lite register byte addresses
`define PAM_ADDR_CPU_CTRL      8'h00
`define PAM_ADDR_PORTA_ALT     8'h04
`define PAM_ADDR_IF_CONFIG     8'h08
`define PAM_ADDR_FIFO_POLARITY 8'h0C
`define PAM_ADDR_WAKE_CTRL     8'h10
`define PAM_ADDR_PORTA_OE      8'h14
`define PAM_ADDR_PORTA_OUT     8'h18
`define PAM_ADDR_PORTA_IN      8'h1C
`define PAM_ADDR_IRQ_STATUS    8'h20
`define PAM_ADDR_IRQ_MASK      8'h24
`define PAM_ADDR_TRIGGER_SEL   8'h28
`define PAM_ADDR_SUSPEND       8'h2C

// cpu control fields
`define PAM_CPU_SPEED_LSB      3
`define PAM_CPU_SPEED_MSB      4
`define PAM_CPU_CLOCK_OUTPUT_PIN_TRI_BIT 1
`define PAM_CPU_CTRL_RST       8'h00

// clock rate codes
`define PAM_SPEED_12           2'h0
`define PAM_SPEED_24           2'h1
`define PAM_SPEED_48           2'h2

// port a alternate config fields
`define PAM_ALT_IRQ0_BIT       0
`define PAM_ALT_IRQ1_BIT       1
`define PAM_ALT_RST            8'h00

// interface mode field
`define PAM_IFMODE_PORTS       2'h0
`define PAM_IFMODE_GPIF        2'h2
`define PAM_IFMODE_FIFO        2'h3
`define PAM_IF_CONFIG_RST      8'h00

`define PAM_POL_READ_EN_BIT    4
`define PAM_FIFO_POLARITY_RST  8'h00

// wake control fields
`define PAM_WAKE_TWO_EN_BIT    1
`define PAM_WAKE_TWO_POL_BIT   4
`define PAM_WAKE_TWO_SEL_BIT   7
`define PAM_WAKE_CTRL_RST      8'h00

`define PAM_PORTA_OE_RST       4'h0
`define PAM_PORTA_OUT_RST      4'h0

// interrupt status bits
`define PAM_IRQ_EXT0_BIT       0
`define PAM_IRQ_EXT1_BIT       1
`define PAM_IRQ_WAKE_BIT       2
`define PAM_IRQ_RST            3'h0
`define PAM_TRIG_RST           2'h0

// axi responses
`define PAM_RESP_OKAY          2'h0
`define PAM_RESP_SLVERR        2'h2

// clock output half periods in clk cycles, minus one
`define PAM_DIV_12_HALF        2'h3
`define PAM_DIV_24_HALF        2'h1
`define PAM_DIV_48_HALF        2'h0

`endif

// ===== verilog/pam_clock_out.v
`timescale 1ns/1ns
`include "pam_consts.vh"

// ----------------------------------------
// clock output rate selection
// ----------------------------------------
// one clk toggle is the top rate; slower rates divide it, phase locked
module pam_clock_out (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [1:0] speed_sel,
    input  wire       tristate,
    output reg        clk_out_r,
    output reg        clk_out_oe_r
);

reg  [1:0] div_cnt_r;
reg  [1:0] div_cnt_nxt;
reg        toggle_now;
reg  [1:0] half_cnt;

always @* begin
    case (speed_sel)
        `PAM_SPEED_48: half_cnt = `PAM_DIV_48_HALF;
        `PAM_SPEED_24: half_cnt = `PAM_DIV_24_HALF;
        default:       half_cnt = `PAM_DIV_12_HALF;
    endcase
    toggle_now  = (div_cnt_r >= half_cnt);
    div_cnt_nxt = toggle_now ? 2'h0 : div_cnt_r + 2'h1;
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        div_cnt_r    <= 2'h0;
        clk_out_r    <= 1'b0;
        clk_out_oe_r <= 1'b1;
    end else begin
        div_cnt_r    <= div_cnt_nxt;
        if (toggle_now)
            clk_out_r <= ~clk_out_r; // R01
        clk_out_oe_r <= ~tristate; // R03
    end
end

endmodule // pam_clock_out

// ===== verilog/pam_irq_detect.v
`timescale 1ns/1ns

// ----------------------------------------
// active low interrupt input, edge or level
// ----------------------------------------
module pam_irq_detect (
    input  wire clk,
    input  wire rst_n,
    input  wire enable,
    input  wire irq_n,
    input  wire edge_sel,
    output reg  event_r
);

reg prev_r;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        prev_r  <= 1'b1;
        event_r <= 1'b0;
    end else begin
        prev_r  <= enable ? irq_n : 1'b1;
        event_r <= enable & ~irq_n & (prev_r | ~edge_sel);
    end
end

endmodule // pam_irq_detect

// ===== verilog/pam_port_a_pins.v
`timescale 1ns/1ns
`include "pam_consts.vh"

// Functional notes
// R01: clock output pin runs at 12, 24 or 48 MHz, locked to input
// R02: processor and clock output run at 12 MHz after reset
// R03: writing cpu control bit 1 to one tri-states clock output pin
// R04: alt config bit 0 picks port bit 0 or external interrupt 0
// R05: interrupt 0 falling edge when trigger bit is 1, low level otherwise
// R06: alt config bit 1 picks port bit 1 or external interrupt 1
// R07: interrupt 1 falling edge when trigger bit is 1, low level otherwise
// R08: interface mode field picks port bit 2 or fifo read drive enable
// R09: fifo read drive enable gates fifo data bus, polarity bit 4
// R10: port bit 3 function chosen by wake bit 7 and output enable bit 3
// R11: wake two enabled by wake bit 1, polarity by wake bit 4
// R12: in suspend, wake two transition restarts oscillator and interrupts
// R13: enabled and asserted wake two refuses entry into suspend
// R14: low reset input returns all pin selections to reset state
// R15: interface mode selects ports, gpif or fifo; ports after power-on
// R16: port bits 0 to 3 come up as inputs after reset
module pam_port_a_pins (
    input  wire        clk,
    input  wire        rst_n,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // port a bits 0..3
    input  wire [3:0]  port_a_in,
    output reg  [3:0]  port_a_out_r,
    output reg  [3:0]  port_a_oe_r,
    // clock output pin
    output wire        clock_output_pin,
    output wire        clock_output_pin_oe,
    // fifo data bus drive
    output reg         fifo_data_bus_drive_r,
    // power management
    output reg         osc_restart_r,
    output reg         suspend_active_r,
    output reg         irq_r
);

// ----------------------------------------
// reset synchroniser
// ----------------------------------------
reg rst_meta_r;
reg rst_sync_r;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rst_meta_r <= 1'b0;
        rst_sync_r <= 1'b0;
    end else begin
        rst_meta_r <= 1'b1;
        rst_sync_r <= rst_meta_r;
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
reg  [7:0] cpu_control_status_reg_r;
reg  [7:0] port_a_alt_config_r;
reg  [7:0] interface_config_reg_r;
reg  [7:0] fifo_pin_polarity_reg_r;
reg  [7:0] wake_ctrl_r;
reg  [3:0] port_a_output_enable_r;
reg  [3:0] port_a_data_r;
reg  [2:0] irq_status_r;
reg  [2:0] irq_mask_r;
reg  [1:0] trig_sel_r;

wire irq0_trigger_sel = trig_sel_r[0];
wire irq1_trigger_sel = trig_sel_r[1];
wire [1:0] if_mode    = interface_config_reg_r[1:0];

wire alt_irq0  = port_a_alt_config_r[`PAM_ALT_IRQ0_BIT]; // R04
wire alt_irq1  = port_a_alt_config_r[`PAM_ALT_IRQ1_BIT]; // R06
wire alt_fifo  = (if_mode == `PAM_IFMODE_FIFO); // R08 R15
wire wake_two_enable   = wake_ctrl_r[`PAM_WAKE_TWO_EN_BIT]; // R11
wire wake_two_polarity = wake_ctrl_r[`PAM_WAKE_TWO_POL_BIT]; // R11
// wake two only while bit 3 is not driven
wire alt_wake  = wake_ctrl_r[`PAM_WAKE_TWO_SEL_BIT] & ~port_a_output_enable_r[3]; // R10

wire ext_irq0_n = port_a_in[0];
wire ext_irq1_n = port_a_in[1];
wire fifo_read_drive_enable = port_a_in[2];
wire wake_pin_two = port_a_in[3];

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
reg        aw_held_r;
reg  [7:0] aw_addr_r;
reg        w_held_r;
reg [31:0] w_data_r;
reg  [3:0] w_strb_r;

wire       aw_fire = s_axi_awvalid & s_axi_awready;
wire       w_fire  = s_axi_wvalid & s_axi_wready;
wire       do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

function addr_known;
    input [7:0] a;
    begin
        addr_known = (a <= `PAM_ADDR_SUSPEND) && (a[1:0] == 2'h0);
    end
endfunction

wire wr_en   = do_write & w_strb_r[0];
wire wr_sel_cpu  = wr_en & (aw_addr_r == `PAM_ADDR_CPU_CTRL);
wire wr_sel_alt  = wr_en & (aw_addr_r == `PAM_ADDR_PORTA_ALT);
wire wr_sel_ifc  = wr_en & (aw_addr_r == `PAM_ADDR_IF_CONFIG);
wire wr_sel_pol  = wr_en & (aw_addr_r == `PAM_ADDR_FIFO_POLARITY);
wire wr_sel_wake = wr_en & (aw_addr_r == `PAM_ADDR_WAKE_CTRL);
wire wr_sel_oe   = wr_en & (aw_addr_r == `PAM_ADDR_PORTA_OE);
wire wr_sel_out  = wr_en & (aw_addr_r == `PAM_ADDR_PORTA_OUT);
wire wr_sel_sts  = wr_en & (aw_addr_r == `PAM_ADDR_IRQ_STATUS);
wire wr_sel_msk  = wr_en & (aw_addr_r == `PAM_ADDR_IRQ_MASK);
wire wr_sel_trg  = wr_en & (aw_addr_r == `PAM_ADDR_TRIGGER_SEL);
wire wr_sel_sus  = wr_en & (aw_addr_r == `PAM_ADDR_SUSPEND);

always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `PAM_RESP_OKAY;
        aw_held_r     <= 1'b0;
        aw_addr_r     <= 8'h00;
        w_held_r      <= 1'b0;
        w_data_r      <= 32'h00000000;
        w_strb_r      <= 4'h0;
    end else begin
        s_axi_awready <= ~aw_held_r & ~aw_fire;
        s_axi_wready  <= ~w_held_r & ~w_fire;
        if (aw_fire) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
        end
        if (w_fire) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr_r) ? `PAM_RESP_OKAY : `PAM_RESP_SLVERR;
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// configuration registers
// ----------------------------------------
always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        cpu_control_status_reg_r <= `PAM_CPU_CTRL_RST; // R02 R14
        port_a_alt_config_r      <= `PAM_ALT_RST; // R14
        interface_config_reg_r   <= `PAM_IF_CONFIG_RST; // R15
        fifo_pin_polarity_reg_r  <= `PAM_FIFO_POLARITY_RST;
        wake_ctrl_r              <= `PAM_WAKE_CTRL_RST;
        port_a_output_enable_r   <= `PAM_PORTA_OE_RST; // R16
        port_a_data_r            <= `PAM_PORTA_OUT_RST;
        irq_mask_r               <= `PAM_IRQ_RST;
        trig_sel_r               <= `PAM_TRIG_RST;
    end else begin
        if (wr_sel_cpu)  cpu_control_status_reg_r <= w_data_r[7:0];
        if (wr_sel_alt)  port_a_alt_config_r      <= w_data_r[7:0];
        if (wr_sel_ifc)  interface_config_reg_r   <= w_data_r[7:0];
        if (wr_sel_pol)  fifo_pin_polarity_reg_r  <= w_data_r[7:0];
        if (wr_sel_wake) wake_ctrl_r              <= w_data_r[7:0];
        if (wr_sel_oe)   port_a_output_enable_r   <= w_data_r[3:0];
        if (wr_sel_out)  port_a_data_r            <= w_data_r[3:0];
        if (wr_sel_msk)  irq_mask_r               <= w_data_r[2:0];
        if (wr_sel_trg)  trig_sel_r               <= w_data_r[1:0];
    end
end

wire suspend_req = wr_sel_sus & w_data_r[0];

// ----------------------------------------
// interrupt sources and pin functions
// ----------------------------------------
wire ev_irq0;
wire ev_irq1;

pam_irq_detect u_irq0 (
    .clk      (clk),
    .rst_n    (rst_sync_r),
    .enable   (alt_irq0),
    .irq_n    (ext_irq0_n),
    .edge_sel (irq0_trigger_sel), // R05
    .event_r  (ev_irq0)
);

pam_irq_detect u_irq1 (
    .clk      (clk),
    .rst_n    (rst_sync_r),
    .enable   (alt_irq1),
    .irq_n    (ext_irq1_n),
    .edge_sel (irq1_trigger_sel), // R07
    .event_r  (ev_irq1)
);

pam_clock_out u_clock_output_pin (
    .clk          (clk),
    .rst_n        (rst_sync_r),
    .speed_sel    (cpu_control_status_reg_r[`PAM_CPU_SPEED_MSB:`PAM_CPU_SPEED_LSB]), // R01 R02
    .tristate     (cpu_control_status_reg_r[`PAM_CPU_CLOCK_OUTPUT_PIN_TRI_BIT]), // R03
    .clk_out_r    (clock_output_pin),
    .clk_out_oe_r (clock_output_pin_oe)
);

reg  wake_prev_r;
wire wake_active = alt_wake & wake_two_enable;
wire wake_asserted = wake_active & (wake_pin_two == wake_two_polarity); // R11 R13
wire wake_edge = wake_active & (wake_pin_two != wake_prev_r); // R12
wire ev_wake = suspend_active_r & wake_edge;

always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        wake_prev_r           <= 1'b0;
        suspend_active_r      <= 1'b0;
        osc_restart_r         <= 1'b0;
        fifo_data_bus_drive_r <= 1'b0;
        port_a_out_r          <= 4'h0;
        port_a_oe_r           <= 4'h0; // R16
        irq_status_r          <= `PAM_IRQ_RST;
        irq_r                 <= 1'b0;
    end else begin
        wake_prev_r <= wake_pin_two;
        if (ev_wake)
            suspend_active_r <= 1'b0; // R12
        else if (suspend_req & ~wake_asserted)
            suspend_active_r <= 1'b1; // R13
        osc_restart_r <= ev_wake; // R12
        fifo_data_bus_drive_r <= alt_fifo &
            (fifo_read_drive_enable == fifo_pin_polarity_reg_r[`PAM_POL_READ_EN_BIT]); // R09
        port_a_out_r <= port_a_data_r;
        port_a_oe_r  <= port_a_output_enable_r &
            {1'b1, ~alt_fifo, ~alt_irq1, ~alt_irq0}; // R04 R06 R08 R10
        // set wins over a write-one clear
        irq_status_r <= (irq_status_r & ~(wr_sel_sts ? w_data_r[2:0] : 3'h0))
                        | {ev_wake, ev_irq1, ev_irq0};
        irq_r <= |(irq_status_r & irq_mask_r);
    end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
function [31:0] read_mux;
    input [7:0] a;
    begin
        case (a)
            `PAM_ADDR_CPU_CTRL:      read_mux = {24'h0, cpu_control_status_reg_r};
            `PAM_ADDR_PORTA_ALT:     read_mux = {24'h0, port_a_alt_config_r};
            `PAM_ADDR_IF_CONFIG:     read_mux = {24'h0, interface_config_reg_r};
            `PAM_ADDR_FIFO_POLARITY: read_mux = {24'h0, fifo_pin_polarity_reg_r};
            `PAM_ADDR_WAKE_CTRL:     read_mux = {24'h0, wake_ctrl_r};
            `PAM_ADDR_PORTA_OE:      read_mux = {28'h0, port_a_output_enable_r};
            `PAM_ADDR_PORTA_OUT:     read_mux = {28'h0, port_a_data_r};
            `PAM_ADDR_PORTA_IN:      read_mux = {28'h0, port_a_in};
            `PAM_ADDR_IRQ_STATUS:    read_mux = {29'h0, irq_status_r};
            `PAM_ADDR_IRQ_MASK:      read_mux = {29'h0, irq_mask_r};
            `PAM_ADDR_TRIGGER_SEL:   read_mux = {30'h0, trig_sel_r};
            `PAM_ADDR_SUSPEND:       read_mux = {30'h0, wake_asserted, suspend_active_r};
            default:                 read_mux = 32'h00000000;
        endcase
    end
endfunction

always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `PAM_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_mux({s_axi_araddr[7:2], 2'h0});
            s_axi_rresp  <= addr_known({s_axi_araddr[7:2], 2'h0}) ? `PAM_RESP_OKAY : `PAM_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // pam_port_a_pins

// ===== test/pam_port_a_props.sv
`timescale 1ns/1ns
`include "pam_consts.vh"

// ----------------------------------------
// port a pin logic checker
// ----------------------------------------
module pam_port_a_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [3:0]  port_a_oe_r,
    input wire logic        clock_output_pin,
    input wire logic        clock_output_pin_oe,
    input wire logic        osc_restart_r,
    input wire logic        suspend_active_r,
    input wire logic        irq_r
);
    logic [7:0] aw_addr_r;
    logic [3:0] stall_r;
    logic       prev_pin_r;
    logic       tog_seen_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_addr_r  <= 8'h00;
            stall_r    <= 4'h0;
            prev_pin_r <= 1'h0;
            tog_seen_r <= 1'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                aw_addr_r <= s_axi_awaddr;
            prev_pin_r <= clock_output_pin;
            stall_r    <= (clock_output_pin != prev_pin_r) ? 4'h0 : stall_r + 4'h1;
            tog_seen_r <= clock_output_pin_oe && (tog_seen_r || clock_output_pin != prev_pin_r);
        end
    end

    sequence s_wr_take;
        s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_wr_answer: assert property (s_wr_take |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_wr_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == ((aw_addr_r <= 8'h2C && aw_addr_r[1:0] == 2'h0)
        ? `PAM_RESP_OKAY : `PAM_RESP_SLVERR)) else $error("write response code wrong");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data late");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_rd_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `PAM_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_clock_output_pin_rate: assert property (tog_seen_r |-> stall_r < 4'h4)
        else $error("clock output too slow");
    a_reset_state: assert property ($rose(rst_n) |-> port_a_oe_r == 4'h0 && clock_output_pin_oe && !irq_r)
        else $error("outputs not at reset state");
    a_wake_pulse: assert property (osc_restart_r |=> !osc_restart_r)
        else $error("restart pulse too long");
    a_wake_cause: assert property (osc_restart_r |-> $past(suspend_active_r) || $past(suspend_active_r, 2))
        else $error("restart without suspend");
endmodule // pam_port_a_props

bind pam_port_a_pins pam_port_a_props u_props (.*);

// ===== test/pam_pin_partner.sv
`timescale 1ns/1ns

// ----------------------------------------
// external party on port a pins
// ----------------------------------------
module pam_pin_partner (
    input  wire logic       clk,
    input  wire logic [3:0] level,
    input  wire logic [3:0] dut_out,
    input  wire logic [3:0] dut_oe,
    output wire logic [3:0] pin
);
    logic [3:0] drive_r;

    initial drive_r = 4'hF;
    // pin levels lag the bench by one cycle
    always @(posedge clk) begin
        drive_r <= level;
    end
    // a pin driven by the block is released by this side
    assign pin = (dut_oe & dut_out) | (~dut_oe & drive_r);
endmodule // pam_pin_partner

// ===== test/testbench.sv
`timescale 1ns/1ns
`include "pam_consts.vh"

module testbench;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rd, seed;
    logic [3:0]  lvl;
    wire         awready, wready, bvalid, arready, rvalid, clk_pin, clk_oe, rd_drive, osc, susp, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [3:0]  pins, pout, poe;
    integer      n_fail, total_checks, cyc, i, j, k, h, md;

    pam_port_a_pins DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_in(pins),
        .port_a_out_r(pout), .port_a_oe_r(poe), .clock_output_pin(clk_pin), .clock_output_pin_oe(clk_oe),
        .fifo_data_bus_drive_r(rd_drive), .osc_restart_r(osc), .suspend_active_r(susp), .irq_r(irq));
    pam_pin_partner u_partner (.clk(clk), .level(lvl), .dut_out(pout), .dut_oe(poe), .pin(pins));

    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [1:0] resp_of(input [7:0] a);
        resp_of = (a <= 8'h2C && a[1:0] == 2'h0) ? `PAM_RESP_OKAY : `PAM_RESP_SLVERR;
    endfunction
    task check(input string name, input [31:0] got, input [31:0] expv);
        begin
            total_checks = total_checks + 1;
            if (got !== expv) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %s expected %h seen %h", name, expv, got);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task settle;
        repeat (6) @(posedge clk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            awaddr  <= a;
            wdata   <= d;
            awvalid <= 1'h1;
            wvalid  <= 1'h1;
            bready  <= 1'h1;
            @(posedge clk);
            while (!bvalid) begin
                if (awready)
                    awvalid <= 1'h0;
                if (wready)
                    wvalid <= 1'h0;
                @(posedge clk);
            end
            bready <= 1'h0;
            check("bresp", {30'h0, bresp}, {30'h0, resp_of(a)});
        end
    endtask
    task rdr(input [7:0] a, output [31:0] d);
        begin
            @(posedge clk);
            araddr  <= a;
            arvalid <= 1'h1;
            rready  <= 1'h1;
            @(posedge clk);
            while (!rvalid) begin
                if (arready)
                    arvalid <= 1'h0;
                @(posedge clk);
            end
            rready <= 1'h0;
            d = rdata;
            check("rresp", {30'h0, rresp}, {30'h0, resp_of(a)});
        end
    endtask
    task half_period(output integer n);
        reg p;
        begin
            repeat (16) @(posedge clk);
            repeat (2) begin
                p = clk_pin;
                n = 0;
                while (clk_pin === p && n < 20) begin
                    @(posedge clk);
                    n = n + 1;
                end
            end
        end
    endtask

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
        lvl = 4'hF;
        seed = 32'heeea;
        n_fail = 0;
        total_checks = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        check("oe_rst", {28'h0, poe}, 32'h0);
        check("clk_oe_rst", {31'h0, clk_oe}, 32'h1);
        for (i = 0; i < 12; i = i + 1) begin
            if (i != 7) begin
                rdr(8'(i * 4), rd);
                check("reg_rst", rd, 32'h0);
            end
        end
        rdr(8'h40, rd);
        wr(8'h44, 32'h1);
        half_period(h);
        check("half_12", h, 4);
        for (i = 2; i >= 0; i = i - 1) begin
            wr(`PAM_ADDR_CPU_CTRL, 32'(i << 3));
            half_period(h);
            check("half_rate", h, 4 >> i);
        end
        wr(`PAM_ADDR_CPU_CTRL, 32'h2);
        settle;
        check("clk_tri", {31'h0, clk_oe}, 32'h0);
        wr(`PAM_ADDR_PORTA_OE, 32'hF);
        for (i = 0; i < 2; i = i + 1) begin
            for (j = 0; j < 2; j = j + 1) begin
                wr(`PAM_ADDR_PORTA_ALT, 32'h0);
                wr(`PAM_ADDR_IRQ_STATUS, 32'h7);
                lvl[i] <= 1'h0;
                settle;
                rdr(`PAM_ADDR_IRQ_STATUS, rd);
                check("irq_off", rd, 32'h0);
                lvl[i] <= 1'h1;
                wr(`PAM_ADDR_TRIGGER_SEL, 32'(j << i));
                wr(`PAM_ADDR_IRQ_MASK, 32'(1 << i));
                wr(`PAM_ADDR_PORTA_ALT, 32'(1 << i));
                wr(`PAM_ADDR_IRQ_STATUS, 32'h7);
                check("irq_oe", {31'h0, poe[i]}, 32'h0);
                lvl[i] <= 1'h0;
                settle;
                rdr(`PAM_ADDR_IRQ_STATUS, rd);
                check("irq_set", rd, 32'(1 << i));
                check("irq_out", {31'h0, irq}, 32'h1);
                wr(`PAM_ADDR_IRQ_STATUS, 32'(1 << i));
                settle;
                rdr(`PAM_ADDR_IRQ_STATUS, rd);
                check("irq_again", rd, j ? 32'h0 : 32'(1 << i));
                wr(`PAM_ADDR_IRQ_MASK, 32'h0);
                settle;
                check("irq_mask", {31'h0, irq}, 32'h0);
                lvl[i] <= 1'h1;
            end
        end
        wr(`PAM_ADDR_PORTA_ALT, 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            md = (i == 0) ? 0 : i + 1;
            for (j = 0; j < 2; j = j + 1) begin
                wr(`PAM_ADDR_IF_CONFIG, 32'(md));
                wr(`PAM_ADDR_FIFO_POLARITY, 32'(j << 4));
                for (k = 0; k < 3; k = k + 1) begin
                    seed = lfsr(seed);
                    lvl[2] <= seed[0];
                    settle;
                    check("rd_drive", {31'h0, rd_drive}, 32'(md == 3 && seed[0] == j));
                end
            end
        end
        wr(`PAM_ADDR_IF_CONFIG, 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            seed = lfsr(seed);
            wr(`PAM_ADDR_PORTA_OUT, {28'h0, seed[3:0]});
            wr(`PAM_ADDR_PORTA_OE, {28'h0, seed[7:4]});
            lvl <= seed[11:8];
            settle;
            check("pout", {28'h0, pout}, {28'h0, seed[3:0]});
            check("poe", {28'h0, poe}, {28'h0, seed[7:4]});
            rdr(`PAM_ADDR_PORTA_IN, rd);
            check("pin", rd, {28'h0, (seed[3:0] & seed[7:4]) | (seed[11:8] & ~seed[7:4])});
        end
        wr(`PAM_ADDR_PORTA_OE, 32'h0);
        for (j = 0; j < 2; j = j + 1) begin
            wr(`PAM_ADDR_WAKE_CTRL, 32'(8'h82 | (j << 4)));
            lvl[3] <= j[0];
            settle;
            wr(`PAM_ADDR_SUSPEND, 32'h1);
            rdr(`PAM_ADDR_SUSPEND, rd);
            check("susp_refused", rd, 32'h2);
        end
        lvl[3] <= 1'h0;
        settle;
        wr(`PAM_ADDR_SUSPEND, 32'h1);
        settle;
        check("susp_on", {31'h0, susp}, 32'h1);
        lvl[3] <= 1'h1;
        k = 0;
        while (!osc && k < 20) begin
            @(posedge clk);
            k = k + 1;
        end
        check("restart", {31'h0, osc}, 32'h1);
        rdr(`PAM_ADDR_IRQ_STATUS, rd);
        check("wake_stat", rd & 32'h4, 32'h4);
        wr(`PAM_ADDR_PORTA_OUT, 32'h8);
        wr(`PAM_ADDR_PORTA_OE, 32'h8);
        settle;
        rdr(`PAM_ADDR_SUSPEND, rd);
        check("wake_port", rd & 32'h2, 32'h0);
        wr(`PAM_ADDR_PORTA_ALT, 32'h3);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        rdr(`PAM_ADDR_PORTA_ALT, rd);
        check("alt_rst", rd, 32'h0);
        check("oe_rst2", {28'h0, poe}, 32'h0);
        end_sim;
    end
endmodule // testbench
